// >>> bcc_consts.vh
// Purpose: shared constants of the branch/call/clear execution block
// Assumes: byte addresses on the register port, 32-bit read data
// Notes:   offsets are word aligned; bits above a field read as zero
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH

// register offsets
`define BCC_A_CTRL      8'h00
`define BCC_A_INSTR     8'h04
`define BCC_A_STATUS    8'h08
`define BCC_A_WREG      8'h0c
`define BCC_A_BANK      8'h10
`define BCC_A_PC        8'h14
`define BCC_A_STKTOP    8'h18
`define BCC_A_SHADOW    8'h1c
`define BCC_A_MADDR     8'h20
`define BCC_A_MDATA     8'h24
`define BCC_A_FSR2      8'h28
`define BCC_A_WDOG      8'h2c

// field positions
`define BCC_CTRL_EXT    0
`define BCC_ST_C        0
`define BCC_ST_DC       1
`define BCC_ST_Z        2
`define BCC_ST_OV       3
`define BCC_ST_N        4
`define BCC_ST_TMO_N    5
`define BCC_ST_PWD_N    6
`define BCC_IS_BUSY     0
`define BCC_IS_V0       1
`define BCC_IS_V1       2

// encodings
`define BCC_OP_BRZ      8'he0
`define BCC_OP_CALL     7'h76
`define BCC_OP_CALL2    4'hf
`define BCC_OP_FCLR     7'h35
`define BCC_OP_DOGCLR   16'h0004
`define BCC_ACC_SPLIT   8'h80
`define BCC_ACC_HIGH    4'hf
`define BCC_IDX_MAX     8'h5f

// reset values
`define BCC_RST_STATUS  5'h00
`define BCC_RST_PC      21'h000000
`define BCC_RST_ZERO8   8'h00

// sizes and timing counts
`define BCC_STK_DEPTH   31
`define BCC_STK_TOP     5'h1f
`define BCC_MEM_WORDS   4096
`define BCC_PC_STEP     21'h000002
`define BCC_DOG_WIDTH   8
`define BCC_DOG_MAX     8'hff
`define BCC_POST_WIDTH  4
`define BCC_POST_MAX    4'hf

`endif

// >>> bcc_wdog.v
// Purpose: watchdog counter with postscaler
// Assumes: one free-running clock, clear is a one-cycle pulse
// Notes:   timeout pulses once when both stages wrap
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_wdog (
    input  wire                        ref_clk,
    input  wire                        rst_n,
    input  wire                        clear,
    output reg  [`BCC_DOG_WIDTH-1:0]   count,
    output reg  [`BCC_POST_WIDTH-1:0]  post,
    output reg                         timeout
);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= `BCC_RST_ZERO8;
            post    <= {`BCC_POST_WIDTH{1'b0}};
            timeout <= 1'b0;
        end else if (clear) begin
            count   <= {`BCC_DOG_WIDTH{1'b0}};
            post    <= {`BCC_POST_WIDTH{1'b0}};
            timeout <= 1'b0;
        end else begin
            count   <= count + 1'b1;
            timeout <= 1'b0;
            if (count == `BCC_DOG_MAX) begin
                post <= post + 1'b1;
                // clear wins over a wrap in the same cycle
                timeout <= (post == `BCC_POST_MAX);
            end
        end
    end

endmodule

// >>> bcc_core.v
// Purpose: executes branch-on-zero, call, clear-register and clear-watchdog
// Assumes: ref_clk is split into four phases that together make one instruction cycle
// Notes:   instruction words are pushed over the register port
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_core (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [7:0]   addr,
    input  wire [31:0]  wdata,
    input  wire         wr_stb,
    input  wire         rd_stb,
    output reg  [31:0]  rdata,
    output reg          busy
);

    // phase and sequencing
    reg  [1:0]   q_reg;
    reg          act_reg;
    reg          nop_reg;
    reg  [15:0]  ir0_reg;
    reg  [15:0]  ir1_reg;
    // two-word instruction holding slots
    reg  [15:0]  w0_reg;
    reg  [15:0]  w1_reg;
    reg          v0_reg;
    reg          v1_reg;
    // architectural state
    reg  [20:0]  pc_reg;
    reg  [4:0]   sp_reg;
    reg  [20:0]  stk [1:`BCC_STK_DEPTH];
    reg  [4:0]   status_reg;
    reg          timeout_flag_n;
    reg          powerdown_flag_n;
    reg  [7:0]   wreg_reg;
    reg  [3:0]   bank_select_register;
    reg  [7:0]   working_shadow;
    reg  [4:0]   status_shadow;
    reg  [3:0]   bank_select_shadow;
    reg          ext_reg;
    reg  [11:0]  fsr2_reg;
    reg  [11:0]  maddr_reg;
    reg  [11:0]  ea_reg;
    reg  [7:0]   dmem [0:`BCC_MEM_WORDS-1];
    reg          dog_clr_reg;

    wire [`BCC_DOG_WIDTH-1:0]   dog_count;
    wire [`BCC_POST_WIDTH-1:0]  dog_post;
    wire                        dog_timeout;

    function is_brz;
        input [15:0] w;
        begin
            is_brz = (w[15:8] == `BCC_OP_BRZ);
        end
    endfunction

    function is_call;
        input [15:0] w;
        begin
            is_call = (w[15:9] == `BCC_OP_CALL);
        end
    endfunction

    function is_fclr;
        input [15:0] w;
        begin
            is_fclr = (w[15:9] == `BCC_OP_FCLR);
        end
    endfunction

    function [11:0] eff_addr;
        input        a;
        input [7:0]  f;
        input        ext;
        input [3:0]  bank;
        input [11:0] fsr2;
        begin
            if (a)
                eff_addr = {bank, f};
            else if (ext && f <= `BCC_IDX_MAX)
                eff_addr = fsr2 + {4'h0, f};
            else if (f < `BCC_ACC_SPLIT)
                eff_addr = {4'h0, f};
            else
                eff_addr = {`BCC_ACC_HIGH, f};
        end
    endfunction

    wire        wr_instr = wr_stb && (addr == `BCC_A_INSTR);
    wire        zero_flag = status_reg[`BCC_ST_Z];
    wire        q1 = (q_reg == 2'd0);
    wire        q2 = (q_reg == 2'd1);
    wire        q3 = (q_reg == 2'd2);
    wire        q4 = (q_reg == 2'd3);
    // a call waits until both of its words are held
    wire        start = q1 && !nop_reg && v0_reg &&
                        (!is_call(w0_reg) || v1_reg);
    wire        x_brz = act_reg && is_brz(ir0_reg);
    wire        x_call = act_reg && is_call(ir0_reg);
    wire        x_fclr = act_reg && is_fclr(ir0_reg);
    wire        x_dogclr = act_reg && (ir0_reg == `BCC_OP_DOGCLR);
    wire        brz_taken = x_brz && zero_flag;
    wire [20:0] br_off = {{12{ir0_reg[7]}}, ir0_reg[7:0], 1'b0};
    wire        fclr_wr = x_fclr && q4;
    wire        idle = !act_reg && !nop_reg;

    // slot queue next values
    reg  [15:0] w0_next;
    reg  [15:0] w1_next;
    reg         v0_next;
    reg         v1_next;

    always @* begin
        w0_next = w0_reg;
        w1_next = w1_reg;
        v0_next = v0_reg;
        v1_next = v1_reg;
        if (start) begin
            if (is_call(w0_reg)) begin
                v0_next = 1'b0;
                v1_next = 1'b0;
            end else begin
                w0_next = w1_reg;
                v0_next = v1_reg;
                v1_next = 1'b0;
            end
        end
        // a push into full slots is dropped; software polls the flags
        if (wr_instr) begin
            if (!v0_next) begin
                w0_next = wdata[15:0];
                v0_next = 1'b1;
            end else if (!v1_next) begin
                w1_next = wdata[15:0];
                v1_next = 1'b1;
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg   <= 2'd0;
            act_reg <= 1'b0;
            nop_reg <= 1'b0;
            ir0_reg <= 16'h0000;
            ir1_reg <= 16'h0000;
            w0_reg  <= 16'h0000;
            w1_reg  <= 16'h0000;
            v0_reg  <= 1'b0;
            v1_reg  <= 1'b0;
            busy    <= 1'b0;
        end else begin
            q_reg  <= q_reg + 2'd1;
            w0_reg <= w0_next;
            w1_reg <= w1_next;
            v0_reg <= v0_next;
            v1_reg <= v1_next;
            if (start) begin
                act_reg <= 1'b1;
                ir0_reg <= w0_reg;
                ir1_reg <= w1_reg;
            end else if (q4) begin
                act_reg <= 1'b0;
            end
            if (q4) begin
                nop_reg <= brz_taken || x_call;
            end
            busy <= v0_next || (act_reg && !q4) || start ||
                    (q4 ? (brz_taken || x_call) : nop_reg);
        end
    end

    // program counter, return stack, shadows
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg             <= `BCC_RST_PC;
            sp_reg             <= 5'h00;
            working_shadow     <= `BCC_RST_ZERO8;
            status_shadow      <= `BCC_RST_STATUS;
            bank_select_shadow <= 4'h0;
        end else begin
            if (start) begin
                pc_reg <= pc_reg + `BCC_PC_STEP;
            end else if (q4 && brz_taken) begin
                pc_reg <= pc_reg + br_off;
            end else if (q4 && x_call) begin
                pc_reg <= {ir1_reg[11:0], ir0_reg[7:0], 1'b0};
            end else if (idle && !v0_reg && wr_stb &&
                         addr == `BCC_A_PC) begin
                pc_reg <= {wdata[20:1], 1'b0};
            end
            if (q3 && x_call) begin
                // a full stack keeps overwriting its top entry
                if (sp_reg != `BCC_STK_TOP)
                    sp_reg <= sp_reg + 5'h01;
                if (ir0_reg[8]) begin
                    working_shadow     <= wreg_reg;
                    status_shadow      <= status_reg;
                    bank_select_shadow <= bank_select_register;
                end
            end
        end
    end

    wire [4:0] push_ptr = (sp_reg == `BCC_STK_TOP) ? sp_reg : sp_reg + 5'h01;

    always @(posedge ref_clk) begin
        if (q3 && x_call)
            stk[push_ptr] <= pc_reg + `BCC_PC_STEP;
    end

    wire [20:0] top_of_stack = (sp_reg == 5'h00) ? 21'h000000 : stk[sp_reg];

    // clear_file_register addressing and write
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ea_reg <= 12'h000;
        end else if (q2 && x_fclr) begin
            ea_reg <= eff_addr(ir0_reg[8], ir0_reg[7:0], ext_reg,
                               bank_select_register, fsr2_reg);
        end
    end

    // the instruction write wins over a software write in the same cycle
    always @(posedge ref_clk) begin
        if (fclr_wr)
            dmem[ea_reg] <= `BCC_RST_ZERO8;
        else if (wr_stb && addr == `BCC_A_MDATA)
            dmem[maddr_reg] <= wdata[7:0];
    end

    // status, flags and software registers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg           <= `BCC_RST_STATUS;
            timeout_flag_n       <= 1'b1;
            powerdown_flag_n     <= 1'b1;
            wreg_reg             <= `BCC_RST_ZERO8;
            bank_select_register <= 4'h0;
            ext_reg              <= 1'b0;
            fsr2_reg             <= 12'h000;
            maddr_reg            <= 12'h000;
            dog_clr_reg          <= 1'b0;
        end else begin
            dog_clr_reg <= q3 && x_dogclr;
            if (wr_stb) begin
                case (addr)
                    `BCC_A_CTRL:  ext_reg <= wdata[`BCC_CTRL_EXT];
                    `BCC_A_WREG:  wreg_reg <= wdata[7:0];
                    `BCC_A_BANK:  bank_select_register <= wdata[3:0];
                    `BCC_A_FSR2:  fsr2_reg <= wdata[11:0];
                    `BCC_A_MADDR: maddr_reg <= wdata[11:0];
                    default: ;
                endcase
            end
            if (fclr_wr)
                status_reg[`BCC_ST_Z] <= 1'b1;
            else if (wr_stb && addr == `BCC_A_STATUS)
                status_reg <= wdata[4:0];
            // the watchdog clear wins over a timeout or a software clear
            if (q3 && x_dogclr)
                timeout_flag_n <= 1'b1;
            else if (dog_timeout)
                timeout_flag_n <= 1'b0;
            else if (wr_stb && addr == `BCC_A_STATUS &&
                     !wdata[`BCC_ST_TMO_N])
                timeout_flag_n <= 1'b0;
            if (q3 && x_dogclr)
                powerdown_flag_n <= 1'b1;
            else if (wr_stb && addr == `BCC_A_STATUS &&
                     !wdata[`BCC_ST_PWD_N])
                powerdown_flag_n <= 1'b0;
        end
    end

    bcc_wdog u_wdog (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (dog_clr_reg),
        .count   (dog_count),
        .post    (dog_post),
        .timeout (dog_timeout)
    );

    // read port: data stand one cycle after the strobe and only there
    reg [31:0] rd_mux;

    always @* begin
        case (addr)
            `BCC_A_CTRL:   rd_mux = {31'h0, ext_reg};
            `BCC_A_INSTR:  rd_mux = {29'h0, v1_reg, v0_reg, busy};
            `BCC_A_STATUS: rd_mux = {25'h0, powerdown_flag_n,
                                     timeout_flag_n, status_reg};
            `BCC_A_WREG:   rd_mux = {24'h0, wreg_reg};
            `BCC_A_BANK:   rd_mux = {28'h0, bank_select_register};
            `BCC_A_PC:     rd_mux = {11'h0, pc_reg};
            `BCC_A_STKTOP: rd_mux = {3'h0, sp_reg, 3'h0, top_of_stack};
            `BCC_A_SHADOW: rd_mux = {15'h0, bank_select_shadow,
                                     status_shadow, working_shadow};
            `BCC_A_MADDR:  rd_mux = {20'h0, maddr_reg};
            `BCC_A_MDATA:  rd_mux = {24'h0, dmem[maddr_reg]};
            `BCC_A_FSR2:   rd_mux = {20'h0, fsr2_reg};
            `BCC_A_WDOG:   rd_mux = {20'h0, dog_post, dog_count};
            default:       rd_mux = 32'h0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rdata <= 32'h0;
        else if (rd_stb)
            rdata <= rd_mux;
        else
            rdata <= 32'h0;
    end

endmodule

// >>> bcc_properties.sv
// Purpose: port checks for the branch/call/clear core
// Assumes: one clock, read answer one cycle after the read strobe
// Notes:   bound to bcc_core below the module
`timescale 1ns/1ps
`include "bcc_consts.vh"
module bcc_props (
    input wire        ref_clk,
    input wire        rst_n,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [31:0] rdata,
    input wire        busy
);
    reg  [31:0] pc_wr_reg;
    reg  [7:0]  ra_reg;
    reg         rv_reg;
    reg  [4:0]  run_reg;
    wire        ins_wr = wr_stb && addr == `BCC_A_INSTR;
    wire        pc_wr  = wr_stb && addr == `BCC_A_PC;
    // busy cycles since the last pushed word, saturating at 31
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_wr_reg <= 32'h0;
            ra_reg    <= 8'h00;
            rv_reg    <= 1'b0;
            run_reg   <= 5'h00;
        end else begin
            if (pc_wr)
                pc_wr_reg <= wdata;
            ra_reg <= addr;
            rv_reg <= rd_stb;
            if (ins_wr || !busy)
                run_reg <= 5'h00;
            else if (run_reg != 5'h1f)
                run_reg <= run_reg + 5'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence pc_wr_rd;
        pc_wr && !busy ##1 !wr_stb ##1 rd_stb && addr == `BCC_A_PC;
    endsequence
    a_rdata_quiet: assert property (!$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data not zero outside an answer");
    a_pc_load: assert property (
        pc_wr_rd |=> rdata == {11'h0, pc_wr_reg[20:1], 1'b0})
        else $error("pc write not read back with bit0 clear");
    a_pc_form: assert property (
        rv_reg && ra_reg == `BCC_A_PC |-> rdata[0] == 1'b0)
        else $error("pc read with odd address");
    a_stktop_form: assert property (
        rv_reg && ra_reg == `BCC_A_STKTOP |-> rdata[0] == 1'b0)
        else $error("return address odd");
    a_status_width: assert property (
        rv_reg && ra_reg == `BCC_A_STATUS |-> rdata[31:7] == 25'h0)
        else $error("status upper bits set");
    a_shadow_width: assert property (
        rv_reg && ra_reg == `BCC_A_SHADOW |-> rdata[31:17] == 15'h0)
        else $error("shadow upper bits set");
    a_wdog_width: assert property (
        rv_reg && ra_reg == `BCC_A_WDOG |-> rdata[31:12] == 20'h0)
        else $error("watchdog upper bits set");
    a_busy_start: assert property (ins_wr |-> ##[1:2] busy)
        else $error("pushed word did not raise busy");
    a_busy_hold: assert property ($rose(busy) |-> busy[*4])
        else $error("instruction shorter than one cycle");
    a_busy_bound: assert property (run_reg < 5'd28)
        else $error("busy held too long");
endmodule
bind bcc_core bcc_props bcc_props_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .busy(busy)
);

// >>> branch_call_clear_instructions_bench.sv
// Purpose: self-checking bench for the branch/call/clear core
// Assumes: register port, read answer one cycle after the strobe
// Notes:   expectations come from an integer model of the core state
`timescale 1ns/1ps
`include "bcc_consts.vh"
module branch_call_clear_instructions_bench;
    reg         ref_clk = 1'b0;
    reg         rst_n   = 1'b0;
    reg  [7:0]  addr    = 8'h00;
    reg  [31:0] wdata   = 32'h0;
    reg         wr_stb  = 1'b0;
    reg         rd_stb  = 1'b0;
    wire [31:0] rdata;
    wire        busy;
    reg  [31:0] v;
    integer     mismatches = 0;
    integer     cmp_count  = 0;
    integer     seed       = 81406;
    integer     cyc        = 0;
    integer     i, t, pc, st, n, k, s, w, b, sh, f, a, e, fx, x;
    integer     stk[$];

    bcc_core dut_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .busy(busy)
    );

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task final_report;
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input [7:0] ad, input [31:0] d);
        @(posedge ref_clk);
        addr   <= ad;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    task rc(input [7:0] ad, input [31:0] m, input [31:0] x);
        @(posedge ref_clk);
        addr   <= ad;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        v = rdata;
        check(v & m, x);
    endtask

    // push one word and wait, bounded, for the core to go idle
    task exec(input [15:0] word, input integer cy);
        wr(`BCC_A_INSTR, {16'h0, word});
        t = 0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        while (busy !== 1'b0 && t < 40) begin
            @(negedge ref_clk);
            t = t + 1;
        end
        check({31'h0, busy}, 32'h0);
        // start waits one to four edges, then cy four-edge cycles run
        v = (t >= 4 * cy - 2 && t <= 4 * cy + 1);
        check(v, 32'h1);
    endtask

    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rc(`BCC_A_PC, 32'hffffffff, 32'h0);
        rc(`BCC_A_STATUS, 32'h7f, 32'h60);
        rc(8'h30, 32'hffffffff, 32'h0);
        pc = $random(seed);
        wr(`BCC_A_PC, pc);
        rc(`BCC_A_PC, 32'hffffffff, pc & 32'h1ffffe);
        // branch: boundaries of the offset, then random; last has wrong op
        for (i = 0; i < 10; i = i + 1) begin
            pc = ($random(seed) & 32'hfffe) | 32'h1000;
            n = (i == 0) ? -128 : (i == 1) ? 127 : $random(seed) % 128;
            st = $random(seed) & 31;
            if (i < 2 || i == 9)
                st = st | 4;
            e = (st & 4) && i != 9;
            wr(`BCC_A_PC, pc);
            wr(`BCC_A_STATUS, st | 32'h60);
            exec({(i == 9) ? 8'he1 : `BCC_OP_BRZ, n[7:0]}, e ? 2 : 1);
            x = (pc + 2 + (e ? 2 * n : 0)) & 32'h1ffffe;
            rc(`BCC_A_PC, 32'hffffffff, x);
            rc(`BCC_A_STATUS, 32'h1f, st);
        end
        for (i = 0; i < 4; i = i + 1) begin
            pc = $random(seed) & 32'h1ffffe;
            k = $random(seed) & 32'hfffff;
            s = (i == 0) ? 1 : $random(seed) & 1;
            w = $random(seed) & 255;
            b = $random(seed) & 15;
            st = $random(seed) & 31;
            wr(`BCC_A_WREG, w);
            wr(`BCC_A_BANK, b);
            wr(`BCC_A_STATUS, st | 32'h60);
            wr(`BCC_A_PC, pc);
            if (s)
                sh = (b << 13) | (st << 8) | w;
            stk.push_back((pc + 4) & 32'h1fffff);
            wr(`BCC_A_INSTR, {16'h0, `BCC_OP_CALL, s[0], k[7:0]});
            exec({`BCC_OP_CALL2, k[19:8]}, 2);
            rc(`BCC_A_PC, 32'hffffffff, k * 2);
            x = (stk.size() << 24) | stk[$];
            rc(`BCC_A_STKTOP, 32'h1f1fffff, x);
            rc(`BCC_A_SHADOW, 32'hffffffff, sh);
            rc(`BCC_A_STATUS, 32'h1f, st);
        end
        // clear: banked, access low/high, indexed and its edges
        for (i = 0; i < 8; i = i + 1) begin
            e = i >= 3;
            a = i == 0 || i == 5;
            f = $random(seed) & 255;
            case (i)
                1: f = f & 127;
                2: f = 128 + (f & 63);
                3, 5: f = f % 96;
                4: f = 96 + (f & 31);
                6: f = 95;
                7: f = 96;
            endcase
            b = $random(seed) & 15;
            fx = $random(seed) & 4095;
            st = $random(seed) & 27;
            x = a ? b * 256 + f : (e && f <= 95) ? (fx + f) % 4096 :
                (f < 128) ? f : 3840 + f;
            wr(`BCC_A_CTRL, e);
            wr(`BCC_A_BANK, b);
            wr(`BCC_A_FSR2, fx);
            wr(`BCC_A_MADDR, x);
            wr(`BCC_A_MDATA, 32'h5a);
            wr(`BCC_A_STATUS, st | 32'h60);
            exec({`BCC_OP_FCLR, a[0], f[7:0]}, 1);
            rc(`BCC_A_MDATA, 32'hff, 32'h0);
            rc(`BCC_A_STATUS, 32'h1f, st | 4);
        end
        wr(`BCC_A_STATUS, 32'h0);
        rc(`BCC_A_STATUS, 32'h7f, 32'h0);
        repeat (600) @(posedge ref_clk);
        exec(`BCC_OP_DOGCLR, 1);
        rc(`BCC_A_STATUS, 32'h7f, 32'h60);
        rc(`BCC_A_WDOG, 32'hfc0, 32'h0);
        final_report;
    end
endmodule
